// ---- rtl/sar_adc_control.sv ----
// successive approximation converter control with its registers
`include "sar_adc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control
  import sar_adc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // register port
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [7:0] rdata_o,
  // analog side
  input wire logic comp_high_i,
  input wire logic limit_pass_i,
  output logic [9:0] tap_code_o,
  output logic comparator_power_on_o,
  output logic converter_clock_en_o,
  output logic converter_resetn_o,
  output logic ext_pos_reference_o,
  output logic ext_neg_reference_o,
  output logic scan_mode_o,
  // events
  output logic conversion_end_irq_o,
  output logic converting_o
);
  logic [7:0] clock_gate;
  mode0_t mode0;
  mode2_t mode2;
  conv_state_t state;
  conv_state_t next_state;
  logic [9:0] approx;
  logic [3:0] bit_idx;
  logic [3:0] settle;
  logic [15:0] wide;
  logic [7:0] high8;

  wire conv_en = clock_gate[`BIT_CONV_EN];
  wire hold_reset = !conv_en;
  wire sel_gate = addr_i == `OFF_CLOCK_GATE;
  wire sel_mode0 = addr_i == `OFF_MODE0;
  wire sel_mode2 = addr_i == `OFF_MODE2;
  wire sel_lo = addr_i == `OFF_RESULT_LO;
  wire sel_hi = addr_i == `OFF_RESULT_HI;
  wire sel_status = addr_i == `OFF_STATUS;
  wire wr_gate = write_i && sel_gate;
  wire wr_mode0 = write_i && sel_mode0 && conv_en;
  wire wr_mode2 = write_i && sel_mode2 && conv_en;
  wire comp_on = mode0.comparator_on && !hold_reset;
  wire run_ok = mode0.run && comp_on;
  wire [3:0] last_bit = mode2.res8 ? 4'd`LAST_BIT_8 : 4'd0;
  wire at_last = bit_idx == last_bit;
  wire settled = settle == 4'h0;
  wire [9:0] with_trial;
  wire [9:0] decided;
  wire load_result = state == ST_DECIDE && settled && at_last;

  sar_step u_step (
    .approx_i(approx),
    .bit_i(bit_idx),
    .comp_high_i(comp_high_i),
    .with_trial_o(with_trial),
    .decided_o(decided)
  );

  result_regs u_result (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .clear_i(hold_reset),
    .load_i(load_result),
    .value_i(decided),
    .wide_o(wide),
    .high8_o(high8)
  );

  always_comb begin
    next_state = state;
    case (state)
      ST_STOP: begin
        if (comp_on) next_state = ST_STANDBY;
      end
      ST_STANDBY: begin
        if (!comp_on) next_state = ST_STOP;
        else if (run_ok) next_state = ST_TRIAL;
      end
      ST_TRIAL: begin
        next_state = ST_DECIDE;
      end
      ST_DECIDE: begin
        if (settled) next_state = at_last ? ST_DONE : ST_TRIAL;
      end
      ST_DONE: begin
        next_state = ST_STANDBY;
      end
      default: begin
        next_state = ST_STOP;
      end
    endcase
    if (hold_reset || !run_ok && state != ST_STOP && state != ST_STANDBY)
      next_state = comp_on ? ST_STANDBY : ST_STOP;
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      clock_gate <= `CLOCK_GATE_RESET;
    end else if (wr_gate) begin
      clock_gate <= wdata_i & `CLOCK_GATE_MASK;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i || hold_reset) begin
      mode0 <= `MODE0_RESET;
      mode2 <= 4'(`MODE2_RESET);
    end else begin
      if (wr_mode0) mode0 <= wdata_i;
      if (wr_mode2) begin
        mode2.pos_hi <= wdata_i[`BIT_POS_REF_HI];
        mode2.pos_lo <= wdata_i[`BIT_POS_REF_LO];
        mode2.neg <= wdata_i[`BIT_NEG_REF];
        mode2.res8 <= wdata_i[`BIT_RES8];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i || hold_reset) begin
      state <= ST_STOP;
      approx <= 10'h000;
      bit_idx <= 4'd`TOP_BIT;
      settle <= 4'h0;
    end else begin
      state <= next_state;
      case (state)
        ST_STANDBY: begin
          approx <= 10'h000;
          bit_idx <= 4'd`TOP_BIT;
        end
        ST_TRIAL: begin
          approx <= with_trial;
          settle <= `SETTLE_CYCLES;
        end
        ST_DECIDE: begin
          if (!settled) settle <= settle - 4'h1;
          else begin
            approx <= decided;
            if (!at_last) bit_idx <= bit_idx - 4'h1;
          end
        end
        default: begin
          settle <= 4'h0;
        end
      endcase
    end
  end

  // outputs registered
  wire [7:0] read_mux =
    sel_gate ? clock_gate :
    sel_mode0 ? {mode0.run, mode0.channel_mode, mode0.clock_sel,
                 mode0.voltage_mode, mode0.comparator_on} :
    sel_mode2 ? {mode2.pos_hi, mode2.pos_lo, mode2.neg, 4'h0, mode2.res8} :
    sel_lo ? wide[7:0] :
    sel_hi ? wide[15:8] :
    sel_status ? high8 : 8'h00;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
      tap_code_o <= 10'h000;
      comparator_power_on_o <= 1'b0;
      converter_clock_en_o <= 1'b0;
      converter_resetn_o <= 1'b0;
      ext_pos_reference_o <= 1'b0;
      ext_neg_reference_o <= 1'b0;
      scan_mode_o <= 1'b0;
      conversion_end_irq_o <= 1'b0;
      converting_o <= 1'b0;
    end else begin
      rdata_o <= read_i ? read_mux : 8'h00;
      tap_code_o <= approx;
      comparator_power_on_o <= comp_on;
      converter_clock_en_o <= conv_en;
      converter_resetn_o <= !hold_reset;
      ext_pos_reference_o <= !mode2.pos_hi && mode2.pos_lo;
      ext_neg_reference_o <= mode2.neg;
      scan_mode_o <= mode0.channel_mode;
      conversion_end_irq_o <= state == ST_DONE && limit_pass_i;
      converting_o <= state == ST_TRIAL || state == ST_DECIDE;
    end
  end
  // only the selected channel is analog; port pins handled elsewhere

  // register and gate checks
  chk_gate_reserved: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    clock_gate[1] == 1'b0 && clock_gate[6] == 1'b0)
    else $error("reserved clock gate bits set");
  chk_gate_mask: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    wr_gate |=> clock_gate == ($past(wdata_i) & `CLOCK_GATE_MASK))
    else $error("clock gate write not taken");
  chk_held_reset: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    $past(hold_reset) |-> mode0 == 8'h00 && state == ST_STOP)
    else $error("converter not held in reset");
  chk_mode0_ignored: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    write_i && sel_mode0 && hold_reset |=> mode0 == 8'h00)
    else $error("mode0 written while gated");
  chk_mode2_ignored: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    write_i && sel_mode2 && hold_reset |=> mode2 == 4'h0)
    else $error("mode2 written while gated");
  chk_result_cleared: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    hold_reset |=> wide == 16'h0000 && high8 == 8'h00)
    else $error("results kept while gated");
  chk_conv_resetn: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    hold_reset |=> !converter_resetn_o)
    else $error("converter reset not driven");
  chk_mode0_write: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    wr_mode0 |=> mode0 == $past(wdata_i))
    else $error("mode0 write not taken");
  chk_scan_follow: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    scan_mode_o == $past(mode0.channel_mode))
    else $error("scan mode output stale");

  // run control and comparator checks
  chk_comp_off: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    !mode0.comparator_on |=> state == ST_STOP)
    else $error("search runs with comparator off");
  chk_power_follow: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    !comp_on |=> !comparator_power_on_o)
    else $error("comparator powered while disabled");
  chk_stop_idle: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_STOP |=> !converting_o)
    else $error("converting flag while stopped");
  chk_trial_run: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_TRIAL |-> $past(run_ok))
    else $error("trial started without run");
  chk_converting_flag: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_DECIDE |=> converting_o)
    else $error("converting flag low during search");

  // search sequence checks
  chk_top_trial: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_STANDBY && next_state == ST_TRIAL |=> ##1
    approx == 10'h200)
    else $error("top trial bit not set");
  chk_standby_clear: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_STANDBY && !hold_reset |=>
    approx == 10'h000 && bit_idx == 4'd`TOP_BIT)
    else $error("search not restarted from top");
  chk_tap_copy: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    tap_code_o == $past(approx))
    else $error("tap code does not follow search");
  chk_trial_sets: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_TRIAL && !hold_reset |=>
    approx == ($past(approx) | (10'h001 << $past(bit_idx))))
    else $error("trial bit not set");
  chk_decide_keep: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_DECIDE && settled && comp_high_i && !hold_reset |=>
    approx == $past(approx))
    else $error("trial bit dropped although input high");
  chk_decide_clear: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_DECIDE && settled && !comp_high_i && !hold_reset |=>
    (approx & (10'h001 << $past(bit_idx))) == 10'h000)
    else $error("trial bit kept although input low");
  chk_bit_step: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_DECIDE && settled && !at_last && !hold_reset |=>
    bit_idx == $past(bit_idx) - 4'h1)
    else $error("search did not move to next bit");
  chk_done_last: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_DONE |-> $past(at_last))
    else $error("conversion ended before last bit");
  chk_last_bit8: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_DONE && mode2.res8 |-> bit_idx == 4'd2)
    else $error("eight bit search did not stop at bit 2");
  chk_step_wait: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_TRIAL && run_ok |=>
    state == ST_DECIDE && settle == `SETTLE_CYCLES)
    else $error("comparator wait too short");
  chk_settle_hold: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_DECIDE && !settled && run_ok |=> state == ST_DECIDE)
    else $error("decide left before settling");

  // result and end event checks
  chk_result_left: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    wide[5:0] == 6'h00)
    else $error("wide result low bits nonzero");
  chk_high_match: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    high8 == wide[15:8])
    else $error("high8 differs from wide result");
  chk_result_load: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    load_result && !hold_reset |=> wide[15:6] == $past(decided))
    else $error("result not loaded");
  chk_irq_done: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    conversion_end_irq_o |-> $past(state) == ST_DONE
    && $past(limit_pass_i))
    else $error("irq without finished conversion");
  chk_irq_pulse: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    conversion_end_irq_o |=> !conversion_end_irq_o)
    else $error("end irq longer than one cycle");
  chk_irq_limit: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_DONE && limit_pass_i |=> conversion_end_irq_o)
    else $error("end irq missing after limit pass");
  chk_irq_blocked: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    state == ST_DONE && !limit_pass_i |=> !conversion_end_irq_o)
    else $error("end irq despite limit block");
endmodule : sar_adc_control
`default_nettype wire

// ---- inc/sar_adc_map.svh ----
// offsets, field positions, reset values and timing counts of the converter
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH
`define ADDR_W 20
`define OFF_CLOCK_GATE 20'hf00f0
`define OFF_MODE0 20'hfff30
`define OFF_MODE2 20'hfff32
`define OFF_RESULT_LO 20'hfff1e
`define OFF_RESULT_HI 20'hfff1f
`define OFF_STATUS 20'hfff34
`define CLOCK_GATE_RESET 8'h00
`define CLOCK_GATE_MASK 8'hbd
`define MODE0_RESET 8'h00
`define MODE2_RESET 8'h00
`define BIT_CONV_EN 5
`define BIT_RUN 7
`define BIT_CHMODE 6
`define BIT_COMP_ON 0
`define BIT_POS_REF_HI 7
`define BIT_POS_REF_LO 6
`define BIT_NEG_REF 5
`define BIT_RES8 0
`define TOP_BIT 9
`define LAST_BIT_8 2
`define SETTLE_CYCLES 4'h2
`endif

// ---- inc/sar_adc_pkg.sv ----
// types of the converter control
package sar_adc_pkg;
  typedef enum logic [2:0] {
    ST_STOP = 3'b000,
    ST_STANDBY = 3'b001,
    ST_TRIAL = 3'b011,
    ST_DECIDE = 3'b010,
    ST_DONE = 3'b110
  } conv_state_t;
  typedef struct packed {
    logic run;
    logic channel_mode;
    logic [2:0] clock_sel;
    logic [1:0] voltage_mode;
    logic comparator_on;
  } mode0_t;
  typedef struct packed {
    logic pos_hi;
    logic pos_lo;
    logic neg;
    logic res8;
  } mode2_t;
endpackage : sar_adc_pkg

// ---- rtl/sar_step.sv ----
// one successive approximation trial and decide step
`timescale 1ns/1ps
`default_nettype none
module sar_step
  import sar_adc_pkg::*;
(
  // search state
  input wire logic [9:0] approx_i,
  input wire logic [3:0] bit_i,
  input wire logic comp_high_i,
  // results
  output logic [9:0] with_trial_o,
  output logic [9:0] decided_o
);
  wire [9:0] one_hot = 10'h001 << bit_i;
  assign with_trial_o = approx_i | one_hot;
  assign decided_o = comp_high_i ? approx_i : (approx_i & ~one_hot);
endmodule : sar_step
`default_nettype wire

// ---- rtl/result_regs.sv ----
// conversion result holding registers
`timescale 1ns/1ps
`default_nettype none
module result_regs
  import sar_adc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // load
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [9:0] value_i,
  // outputs
  output logic [15:0] wide_o,
  output logic [7:0] high8_o
);
  always_ff @(posedge clock_i) begin
    if (!resetn_i || clear_i) begin
      wide_o <= 16'h0000;
      high8_o <= 8'h00;
    end else if (load_i) begin
      wide_o <= {value_i, 6'h00};
      high8_o <= value_i[9:2];
    end
  end
endmodule : result_regs
`default_nettype wire

// ---- testbench/analog_model.sv ----
// comparator and limit checker model at the analog side
`timescale 1ns/1ps
`default_nettype none
module analog_model (
  // clock
  input wire logic clock_i,
  // from the controller
  input wire logic power_on_i,
  input wire logic [9:0] tap_code_i,
  // stimulus
  input wire logic [9:0] level_i,
  input wire logic limit_en_i,
  // to the controller
  output logic comp_high_o,
  output logic limit_pass_o
);
  logic noise = 1'b0;
  // a stopped comparator gives no steady answer
  always @(posedge clock_i) begin
    noise <= ~noise;
  end
  assign comp_high_o = power_on_i ? (level_i >= tap_code_i) : noise;
  assign limit_pass_o = limit_en_i;
endmodule : analog_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// register level tests of the converter control
`include "sar_adc_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [19:0] addr_i = 20'h00000;
  logic [7:0] wdata_i = 8'h00;
  logic write_i = 1'b0;
  logic read_i = 1'b0;
  logic [7:0] rdata_o;
  logic comp_high_i, limit_pass_i, power_on, clk_en, conv_resetn;
  logic ext_pos, ext_neg, scan_mode, irq, converting;
  logic [9:0] tap_code;
  logic [9:0] level = 10'h000;
  logic limit_en = 1'b1;
  logic [7:0] rv;
  logic [9:0] lvls [7] = '{10'h3ff, 10'h000, 10'h200, 10'h1ff, 10'h2a7,
    10'h2a7, 10'h3ff};
  int err_count = 0;
  int comparisons = 0;
  int n, p10, p8;
  always #4 clock_i = ~clock_i;
  sar_adc_control u_dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
    .rdata_o(rdata_o), .comp_high_i(comp_high_i),
    .limit_pass_i(limit_pass_i), .tap_code_o(tap_code),
    .comparator_power_on_o(power_on), .converter_clock_en_o(clk_en),
    .converter_resetn_o(conv_resetn), .ext_pos_reference_o(ext_pos),
    .ext_neg_reference_o(ext_neg), .scan_mode_o(scan_mode),
    .conversion_end_irq_o(irq), .converting_o(converting));
  analog_model u_analog (.clock_i(clock_i), .power_on_i(power_on),
    .tap_code_i(tap_code), .level_i(level), .limit_en_i(limit_en),
    .comp_high_o(comp_high_i), .limit_pass_o(limit_pass_i));
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  // count cycles up to the next end pulse, bounded
  task automatic wait_irq(output int c);
    c = 0;
    do begin
      @(posedge clock_i);
      #1 c++;
    end while (irq !== 1'b1 && c < 300);
    if (c >= 300) begin
      err_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, 0, 1);
      stop_test();
    end
  endtask : wait_irq
  task automatic conv(input logic [9:0] lv, input logic r8, output int per);
    logic [9:0] e;
    e = r8 ? {lv[9:2], 2'b00} : lv;
    level <= lv;
    wr(`OFF_MODE2, {7'h00, r8});
    wr(`OFF_MODE0, 8'h81);
    wait_irq(n);
    repeat (2) @(posedge clock_i);
    #1 `CHECK(converting, 1'b1)
    rd(`OFF_MODE0, rv);
    `CHECK(rv, 8'h81)
    wait_irq(n);
    wait_irq(per);
    wr(`OFF_MODE0, 8'h01);
    repeat (2) @(posedge clock_i);
    #1 `CHECK(converting, 1'b0)
    rd(`OFF_RESULT_LO, rv);
    `CHECK(rv, {e[1:0], 6'h00})
    rd(`OFF_RESULT_HI, rv);
    `CHECK(rv, e[9:2])
    rd(`OFF_STATUS, rv);
    `CHECK(rv, e[9:2])
    $display("test conversion %0h res8 %0d done", lv, r8);
  endtask : conv
  initial begin
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(`OFF_CLOCK_GATE, rv);
    `CHECK(rv, 8'h00)
    rd(`OFF_MODE0, rv);
    `CHECK(rv, 8'h00)
    wr(`OFF_MODE0, 8'h01);
    rd(`OFF_MODE0, rv);
    `CHECK(rv, 8'h00)
    `CHECK(conv_resetn, 1'b0)
    $display("test reset and gate closed done");
    wr(`OFF_CLOCK_GATE, 8'hff);
    rd(`OFF_CLOCK_GATE, rv);
    `CHECK(rv, 8'hbd)
    `CHECK({clk_en, conv_resetn}, 2'b11)
    wr(`OFF_MODE0, 8'h01);
    rd(`OFF_MODE0, rv);
    `CHECK(rv, 8'h01)
    `CHECK({power_on, converting}, 2'b10)
    wr(`OFF_MODE2, 8'h60);
    wr(`OFF_MODE0, 8'h41);
    @(posedge clock_i);
    #1 `CHECK({ext_pos, ext_neg, scan_mode}, 3'b111)
    `CHECK(ext_neg, 1'b1)
    wr(`OFF_MODE2, 8'ha0);
    wr(`OFF_MODE0, 8'h00);
    @(posedge clock_i);
    #1 `CHECK({ext_pos, scan_mode, power_on}, 3'b000)
    wr(`OFF_MODE0, 8'h01);
    $display("test mode fields done");
    for (int i = 0; i < 7; i++) begin
      conv(lvls[i], i >= 5, n);
      if (i == 4) p10 = n;
      if (i == 6) p8 = n;
    end
    `CHECK(p10 - p8, 8)
    limit_en <= 1'b0;
    level <= 10'h155;
    wr(`OFF_MODE2, 8'h00);
    wr(`OFF_MODE0, 8'h81);
    n = 0;
    repeat (150) begin
      @(posedge clock_i);
      #1 if (irq === 1'b1) n++;
    end
    `CHECK(n, 0)
    wr(`OFF_MODE0, 8'h01);
    rd(`OFF_STATUS, rv);
    `CHECK(rv, 8'h55)
    $display("test limit hold done");
    wr(`OFF_CLOCK_GATE, 8'h00);
    rd(`OFF_MODE0, rv);
    `CHECK(rv, 8'h00)
    rd(`OFF_STATUS, rv);
    `CHECK(rv, 8'h00)
    `CHECK(conv_resetn, 1'b0)
    $display("test gate off done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
